// file: logic/ocram_map.vh
// Address map, field positions and reset values of the on-chip RAM block
`ifndef OCRAM_MAP_VH
`define OCRAM_MAP_VH
`define OCRAM_SYS_CTRL_OFFSET 24'h0EE012
`define OCRAM_SYS_CTRL_RESET 8'h09
`define OCRAM_MEN_BIT 0
`define OCRAM_MEN_RESET 1'b1
`define OCRAM_MODE_3 3'h3
`define OCRAM_MODE_4 3'h4
`define OCRAM_WIN_LO_SHORT 24'h0FEF20
`define OCRAM_WIN_HI_SHORT 24'h0FFF1F
`define OCRAM_WIN_LO_LONG 24'hFFEF20
`define OCRAM_WIN_HI_LONG 24'hFFFF1F
`define OCRAM_ADDR_MASK_SHORT 24'h0FFFFF
`define OCRAM_WORDS 2048
`define OCRAM_IDX_W 11
`define OCRAM_ACCESS_STATES 2
`endif

// file: logic/ocram_bank.v
// One byte lane of the RAM array, flip-flop storage indexed by word
`include "ocram_map.vh"
module ocram_bank (
  input wire clk,
  input wire we,
  input wire [`OCRAM_IDX_W-1:0] idx,
  input wire [7:0] wdata,
  output reg [7:0] rdata
);
  reg [7:0] mem [0:`OCRAM_WORDS-1];
  always @(posedge clk) begin
    if (we) begin
      mem[idx] <= wdata;
    end
    rdata <= mem[idx];
  end
endmodule // ocram_bank

// file: logic/ocram_ctrl.v
// On-chip RAM access control: window decode, enable bit, two-state access
//
// Added by the designer: the plain strobed port.
`include "ocram_map.vh"
// How it works
// - With enable set and software standby clear, the mode's 4-kbyte window reaches the RAM.
// - With enable clear in modes 1-4, window accesses go to external space.
// - Enable is bit 0 of system_control; 1 enables, reset value enables.
// - Enable bit takes its initial value asynchronously as soon as external reset is asserted.
// - Software standby does not change the enable bit.
// - Byte access takes two states, data on upper eight bus bits.
// - Word access at even address takes two states, uses all sixteen bits.
module ocram_ctrl (
  input wire clk,
  input wire reset,
  input wire [2:0] mode,
  input wire sw_standby,
  input wire [23:0] cpu_addr,
  input wire cpu_req,
  input wire cpu_write,
  input wire cpu_word,
  input wire [15:0] cpu_wdata,
  input wire [23:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [7:0] reg_rdata,
  output reg [15:0] cpu_rdata,
  output reg cpu_done,
  output reg ext_access,
  output reg onchip_mem_enable_out
);
  localparam ST_IDLE = 2'b01;
  localparam ST_T2 = 2'b10;

  reg [7:0] system_control_reg;
  reg [1:0] state_reg;
  reg [1:0] state_next;
  reg [2:0] mode_s1_reg;
  reg [2:0] mode_s2_reg;
  reg long_map;
  reg hi_we_reg;
  reg lo_we_reg;
  reg [`OCRAM_IDX_W-1:0] idx_reg;
  reg [15:0] wdata_reg;
  reg word_reg;
  reg odd_reg;
  reg rd_reg;
  wire [7:0] hi_q;
  wire [7:0] lo_q;
  wire [7:0] byte_q;
  wire [23:0] eff_addr;
  wire [23:0] win_lo;
  wire [23:0] win_hi;
  wire in_win;
  wire hit;
  wire take;
  wire sys_ctrl_sel;
  wire [23:0] off;
  wire [`OCRAM_IDX_W-1:0] bank_idx;

  // Mode straps are pins, so all three bits pass two flip-flops first
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      mode_s1_reg <= 3'h0;
      mode_s2_reg <= 3'h0;
    end else begin
      mode_s1_reg <= mode;
      mode_s2_reg <= mode_s1_reg;
    end
  end

  // Modes 3 and 4 use the 24-bit window, every other value the short one
  always @* begin
    case (mode_s2_reg)
      `OCRAM_MODE_3: begin
        long_map = 1'b1;
      end
      `OCRAM_MODE_4: begin
        long_map = 1'b1;
      end
      default: begin
        long_map = 1'b0;
      end
    endcase
  end

  // Short-window modes decode only the low 20 address bits, so the
  // upper nibble aliases; software must not rely on it for protection
  assign eff_addr = long_map ? cpu_addr :
    (cpu_addr & `OCRAM_ADDR_MASK_SHORT);
  assign win_lo = long_map ? `OCRAM_WIN_LO_LONG : `OCRAM_WIN_LO_SHORT;
  assign win_hi = long_map ? `OCRAM_WIN_HI_LONG : `OCRAM_WIN_HI_SHORT;
  assign in_win = (eff_addr >= win_lo) && (eff_addr <= win_hi);
  assign hit = in_win & system_control_reg[`OCRAM_MEN_BIT];
  assign off = eff_addr - win_lo;
  assign take = (state_reg == ST_IDLE) && cpu_req && hit && !sw_standby;
  assign sys_ctrl_sel = (reg_addr == `OCRAM_SYS_CTRL_OFFSET);

  // The array is read at the request edge so data is ready in the
  // second state; writes use the captured index in that state
  assign bank_idx = (state_reg == ST_IDLE) ?
    off[`OCRAM_IDX_W:1] : idx_reg;

  // Only reset loads the initial value; standby has no path here
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      system_control_reg <= `OCRAM_SYS_CTRL_RESET;
    end else if (reg_wr && sys_ctrl_sel) begin
      system_control_reg <= reg_wdata;
    end
  end

  // Other addresses read as zero
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd && sys_ctrl_sel) begin
      reg_rdata <= system_control_reg;
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  always @(posedge clk or posedge reset) begin
    if (reset) begin
      onchip_mem_enable_out <= `OCRAM_MEN_RESET;
    end else begin
      onchip_mem_enable_out <= system_control_reg[`OCRAM_MEN_BIT];
    end
  end

  always @* begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (take) begin
          state_next = ST_T2;
        end
      end
      ST_T2: state_next = ST_IDLE;
      default: state_next = ST_IDLE;
    endcase
  end

  always @(posedge clk or posedge reset) begin
    if (reset) begin
      state_reg <= ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // Request capture: index, lane and write enables for the second state
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      hi_we_reg <= 1'b0;
      lo_we_reg <= 1'b0;
      idx_reg <= {`OCRAM_IDX_W{1'b0}};
      wdata_reg <= 16'h0000;
      word_reg <= 1'b0;
      odd_reg <= 1'b0;
      rd_reg <= 1'b0;
    end else begin
      hi_we_reg <= 1'b0;
      lo_we_reg <= 1'b0;
      rd_reg <= 1'b0;
      if (take) begin
        idx_reg <= off[`OCRAM_IDX_W:1];
        odd_reg <= off[0];
        word_reg <= cpu_word;
        rd_reg <= ~cpu_write;
        if (cpu_word) begin
          // Words are taken as even; the odd address bit is ignored
          wdata_reg <= cpu_wdata;
          hi_we_reg <= cpu_write;
          lo_we_reg <= cpu_write;
        end else begin
          // Byte data rides the upper lane; only its own half is written
          wdata_reg <= {cpu_wdata[15:8], cpu_wdata[15:8]};
          hi_we_reg <= cpu_write & ~off[0];
          lo_we_reg <= cpu_write & off[0];
        end
      end
    end
  end

  assign byte_q = odd_reg ? lo_q : hi_q;

  // Second state: done pulse and read data; writes return zero data
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      cpu_done <= 1'b0;
      cpu_rdata <= 16'h0000;
    end else begin
      cpu_done <= 1'b0;
      if (state_reg == ST_T2) begin
        cpu_done <= 1'b1;
        if (!rd_reg) begin
          cpu_rdata <= 16'h0000;
        end else if (word_reg) begin
          cpu_rdata <= {hi_q, lo_q};
        end else begin
          cpu_rdata <= {byte_q, 8'h00};
        end
      end
    end
  end

  // Disabled window goes off chip in the expanded modes
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      ext_access <= 1'b0;
    end else begin
      ext_access <= cpu_req && !hit && (state_reg == ST_IDLE);
    end
  end

  ocram_bank u_hi (
    .clk(clk),
    .we(hi_we_reg),
    .idx(bank_idx),
    .wdata(wdata_reg[15:8]),
    .rdata(hi_q)
  );

  ocram_bank u_lo (
    .clk(clk),
    .we(lo_we_reg),
    .idx(bank_idx),
    .wdata(wdata_reg[7:0]),
    .rdata(lo_q)
  );
endmodule // ocram_ctrl

// file: test/orac_properties.sv
// Port checks for the on-chip RAM access control
`include "ocram_map.vh"
module orac_properties (
  input logic clk,
  input logic reset,
  input logic cpu_req,
  input logic cpu_write,
  input logic cpu_word,
  input logic reg_wr,
  input logic reg_rd,
  input logic cpu_done,
  input logic ext_access,
  input logic onchip_mem_enable_out,
  input logic [23:0] reg_addr,
  input logic [7:0] reg_wdata,
  input logic [7:0] reg_rdata,
  input logic [15:0] cpu_rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  wire hit = reg_addr == `OCRAM_SYS_CTRL_OFFSET;
  wire hw = reg_wr && hit;
  a_two_states: assert property ($rose(cpu_done) |-> $past(cpu_req, 2))
    else $error("late done");
  a_miss_out: assert property (ext_access |=> !cpu_done)
    else $error("miss done");
  a_en_write: assert property (hw |=> ##1
    onchip_mem_enable_out == $past(reg_wdata[0], 2)) else $error("en write");
  a_en_hold: assert property (!hw [*2] |=> $stable(onchip_mem_enable_out))
    else $error("en moved");
  a_done_pulse: assert property (cpu_done |=> !cpu_done)
    else $error("done too long");
  a_refused_rd: assert property (reg_rd && !hit |=> reg_rdata == 8'h00)
    else $error("bad rd");
  a_rd_value: assert property (reg_rd && hit |=>
    reg_rdata[0] == onchip_mem_enable_out) else $error("rd value");
  a_reset_on: assert property ($fell(reset) |-> onchip_mem_enable_out)
    else $error("en reset");
  a_byte_lane: assert property (cpu_req && !cpu_word && !cpu_write
    ##2 cpu_done |-> cpu_rdata[7:0] == 8'h00) else $error("lane");
endmodule // orac_properties

// file: test/orac_cpu.sv
// CPU core model issuing RAM accesses
module orac_cpu (
  input logic clk,
  input logic cpu_done,
  input logic ext_access,
  input logic [15:0] cpu_rdata,
  output logic [23:0] cpu_addr = '0,
  output logic [15:0] cpu_wdata = '0,
  output logic cpu_req = 0,
  output logic cpu_write = 0,
  output logic cpu_word = 0
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] q;
  logic x, dn;
  // Released lines show the inverse, so a late sample cannot pass
  task acc(logic [23:0] a, logic w, k, logic [15:0] d);
    {cpu_addr, cpu_write, cpu_word, cpu_wdata, cpu_req} <= {a, w, k, d, 1'b1};
    @(posedge clk) {cpu_addr, cpu_write, cpu_word, cpu_wdata, cpu_req} <=
      {~a, ~w, ~k, ~d, 1'b0};
    #1 x = ext_access;
    @(posedge clk) #1 q = cpu_rdata;
    dn = cpu_done;
    @(posedge clk);
  endtask
endmodule // orac_cpu

// file: test/onchip_ram_access_control_test.sv
// Bench for the on-chip RAM access control
`include "ocram_map.vh"
module onchip_ram_access_control_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, reset = 1, sw_standby = 0, reg_wr = 0, reg_rd = 0;
  logic cpu_req, cpu_write, cpu_word, cpu_done, ext_access;
  logic onchip_mem_enable_out;
  logic [2:0] mode = 3'h3;
  logic [23:0] reg_addr = '0, cpu_addr;
  logic [7:0] reg_wdata = '0, reg_rdata, v;
  logic [15:0] cpu_wdata, cpu_rdata;
  int n_errors = 0, checked = 0;
  localparam logic [23:0] R = `OCRAM_SYS_CTRL_OFFSET;
  always #4 clk = ~clk;
  ocram_ctrl dut (.clk, .reset, .mode, .sw_standby, .cpu_addr, .cpu_req,
    .cpu_write, .cpu_word, .cpu_wdata, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .cpu_rdata, .cpu_done, .ext_access,
    .onchip_mem_enable_out);
  orac_cpu c (.clk, .cpu_done, .ext_access, .cpu_rdata, .cpu_addr,
    .cpu_req, .cpu_write, .cpu_word, .cpu_wdata);
  task chk(string s, logic [15:0] e, g);
    checked++;
    if (g !== e) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", s, e, g);
    end
  endtask
  task rw(logic [23:0] a, logic [7:0] d);
    {reg_addr, reg_wdata, reg_wr} <= {a, d, 1'b1};
    @(posedge clk) reg_wr <= 0;
  endtask
  task rr(logic [23:0] a);
    {reg_addr, reg_rd} <= {a, 1'b1};
    @(posedge clk) reg_rd <= 0;
    #1 v = reg_rdata;
    @(posedge clk);
  endtask
  task t_ram;
    rr(R);
    chk("control", 16'h0009, v);
    c.acc(24'hFFEF20, 1, 1, 16'hA55A);
    chk("word write done", 16'h0001, c.dn);
    chk("word write local", 16'h0000, c.x);
    c.acc(24'hFFEF21, 1, 0, 16'h3C77);
    chk("byte write done", 16'h0001, c.dn);
    c.acc(24'hFFEF20, 0, 1, 16'h0000);
    chk("word", 16'hA53C, c.q);
    c.acc(24'hFFEF20, 0, 0, 16'h0000);
    chk("byte", 16'hA500, c.q);
    c.acc(24'hFFEF21, 0, 0, 16'h0000);
    chk("odd byte", 16'h3C00, c.q);
    c.acc(24'hFFFF1F, 1, 0, 16'h5A11);
    c.acc(24'hFFFF1F, 0, 0, 16'h0000);
    chk("top byte", 16'h5A00, c.q);
    c.acc(24'hFFEF1F, 0, 0, 16'h0000);
    chk("below window", 16'h0001, c.x);
    c.acc(24'hFFFF20, 0, 1, 16'h0000);
    chk("outside", 16'h0001, c.x);
    chk("outside done", 16'h0000, c.dn);
    $display("t_ram end");
  endtask
  task t_off;
    rw(R, 8'h08);
    c.acc(24'hFFEF20, 0, 1, 16'h0000);
    chk("disabled", 16'h0001, c.x);
    chk("disabled done", 16'h0000, c.dn);
    sw_standby <= 1;
    repeat (4) @(posedge clk);
    sw_standby <= 0;
    rr(R);
    chk("kept", 16'h0008, v);
    rr(R + 24'h000001);
    chk("unmapped", 16'h0000, v);
    rw(R, 8'h09);
    sw_standby <= 1;
    c.acc(24'hFFEF20, 0, 1, 16'h0000);
    chk("standby blocks", 16'h0000, c.dn);
    chk("standby local", 16'h0000, c.x);
    sw_standby <= 0;
    $display("t_off end");
  endtask
  task t_mode1;
    mode <= 3'h1;
    repeat (3) @(posedge clk);
    c.acc(24'h0FEF20, 0, 1, 16'h0000);
    chk("short hit", 16'hA53C, c.q);
    chk("short done", 16'h0001, c.dn);
    c.acc(24'h0FFF20, 0, 1, 16'h0000);
    chk("short outside", 16'h0001, c.x);
    mode <= 3'h2;
    repeat (3) @(posedge clk);
    c.acc(24'h0FEF20, 0, 1, 16'h0000);
    chk("mode 2 done", 16'h0001, c.dn);
    chk("mode 2 hit", 16'hA53C, c.q);
    mode <= 3'h4;
    repeat (3) @(posedge clk);
    c.acc(24'hFFEF20, 0, 1, 16'h0000);
    chk("mode 4 done", 16'h0001, c.dn);
    c.acc(24'h0FEF20, 0, 1, 16'h0000);
    chk("mode 4 short", 16'h0001, c.x);
    $display("t_mode1 end");
  endtask
  task finish_test;
    $display("checks %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge clk);
    reset <= 0;
    @(posedge clk);
    t_ram;
    t_off;
    t_mode1;
    finish_test;
  end
  initial begin
    #20000;
    n_errors++;
    finish_test;
  end
endmodule // onchip_ram_access_control_test
bind ocram_ctrl orac_properties u_chk (.clk, .reset, .cpu_req, .cpu_write,
  .cpu_word, .reg_wr, .reg_rd, .cpu_done, .ext_access,
  .onchip_mem_enable_out, .reg_addr, .reg_wdata, .reg_rdata, .cpu_rdata);
